// ### common/sfr_pkg.sv
// Package with register map, field layout, reset values and shared types for the register core.
package sfr_pkg;

   // ----------------------------------------------------------------
   // Address map
   // ----------------------------------------------------------------
   localparam logic [7:0] SFR_BASE = 8'h80;
   localparam logic [7:0] POWER_CONTROL_ADDR = 8'h87;
   localparam logic [7:0] EXT_IRQ_PRIO_ONE_ADDR = 8'hf3;
   localparam logic [3:0] BIT_ADDR_NIB_A = 4'h0;
   localparam logic [3:0] BIT_ADDR_NIB_B = 4'h8;

   // ----------------------------------------------------------------
   // Field layout and reset values
   // ----------------------------------------------------------------
   localparam int STOP_BIT = 1;
   localparam int IDLE_BIT = 0;
   localparam logic [7:0] POWER_CONTROL_RESET = 8'h00;
   localparam int COMPARATOR_IRQ_LEVEL_BIT = 5;
   localparam int COUNTER_ARRAY_IRQ_LEVEL_BIT = 4;
   localparam int CONVERSION_DONE_IRQ_LEVEL_BIT = 3;
   localparam int WINDOW_COMPARE_IRQ_LEVEL_BIT = 2;
   localparam int PIN_MATCH_IRQ_LEVEL_BIT = 1;
   localparam int TWO_WIRE_IRQ_LEVEL_BIT = 0;
   localparam logic [7:0] EXT_IRQ_PRIO_ONE_RESET = 8'h00;
   localparam logic [7:0] EXT_IRQ_PRIO_ONE_WMASK = 8'h3f;
   localparam int NUM_SRC = 6;
   localparam logic [7:0] RESET_VECTOR = 8'h00;

   // ----------------------------------------------------------------
   // Shared types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic rd;
      logic wr;
      logic bit_op;
      logic [2:0] bit_sel;
      logic [7:0] addr;
      logic [7:0] wdata;
   } sfr_req_t;

   typedef struct packed {
      logic sfr_sel;
      logic bit_ok;
      logic pwr_hit;
      logic prio_hit;
   } sfr_dec_t;

endpackage : sfr_pkg

// ### logic/sfr_decode.sv
// Address decoder for the register window.
`timescale 1ns/1ps
module sfr_decode
(
   input wire sfr_pkg::sfr_req_t req,
   output sfr_pkg::sfr_dec_t dec
);

   // Upper half of direct space selects registers; bit access only on column 0 or 8.
   always_comb
   begin
      dec.sfr_sel = req.addr[7];
      dec.bit_ok = (req.addr[3:0] == sfr_pkg::BIT_ADDR_NIB_A) ||
                   (req.addr[3:0] == sfr_pkg::BIT_ADDR_NIB_B);
      dec.pwr_hit = dec.sfr_sel && (req.addr == sfr_pkg::POWER_CONTROL_ADDR);
      dec.prio_hit = dec.sfr_sel && (req.addr == sfr_pkg::EXT_IRQ_PRIO_ONE_ADDR);
   end

endmodule : sfr_decode

// ### logic/irq_level_arbiter.sv
// Two-level interrupt arbiter for the six extended sources.
`timescale 1ns/1ps
module irq_level_arbiter
(
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic [5:0] irq_req,
   input wire logic [5:0] level,
   input wire logic irq_ack,
   input wire logic irq_ret,
   output logic irq_take,
   output logic [2:0] irq_id
);

   logic in_low_ff;
   logic in_high_ff;
   logic [5:0] hi_req;
   logic [5:0] lo_req;
   logic [2:0] hi_id;
   logic [2:0] lo_id;

   // Split pending requests by their programmed level and pick lowest index.
   always_comb
   begin
      hi_req = irq_req & level;
      lo_req = irq_req & ~level;
      hi_id = 3'h0;
      lo_id = 3'h0;
      for (int i = 5; i >= 0; i--)
      begin
         if (hi_req[i])
            hi_id = 3'(i);
         if (lo_req[i])
            lo_id = 3'(i);
      end
      irq_take = 1'b0;
      irq_id = lo_id;
      if (!in_high_ff && (hi_req != 6'h00))
      begin
         irq_take = 1'b1;
         irq_id = hi_id;
      end
      else if (!in_high_ff && !in_low_ff && (lo_req != 6'h00))
         irq_take = 1'b1;
   end

   // Tracks which service levels are active; return closes the highest one.
   always_ff @(posedge clk_sys)
   begin
      if (!resetn)
      begin
         in_low_ff <= 1'b0;
         in_high_ff <= 1'b0;
      end
      else if (irq_ack && irq_take)
      begin
         if (level[irq_id])
            in_high_ff <= 1'b1;
         else
            in_low_ff <= 1'b1;
      end
      else if (irq_ret)
      begin
         if (in_high_ff)
            in_high_ff <= 1'b0;
         else
            in_low_ff <= 1'b0;
      end
   end

endmodule : irq_level_arbiter

// ### logic/core_sfr_space_priority_stop.sv
// Register window, extended priority register, arbiter and stop-mode control.
`timescale 1ns/1ps
module core_sfr_space_priority_stop
(
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic ext_reset_req,
   input wire logic detector_enable,
   input wire logic detector_timeout,
   input wire logic acc_rd,
   input wire logic acc_wr,
   input wire logic acc_bit_op,
   input wire logic [2:0] acc_bit_sel,
   input wire logic [7:0] acc_addr,
   input wire logic [7:0] acc_wdata,
   input wire logic instr_done,
   input wire logic [7:0] periph_rdata,
   input wire logic [5:0] irq_req,
   input wire logic irq_ack,
   input wire logic irq_ret,
   output logic [7:0] rdata,
   output logic ram_sel,
   output logic periph_sel,
   output logic bit_refused,
   output logic stop_mode,
   output logic osc_run,
   output logic core_run,
   output logic periph_run,
   output logic core_reset_req,
   output logic [7:0] fetch_addr,
   output logic [5:0] irq_level,
   output logic irq_take,
   output logic [2:0] irq_id
);

   // ----------------------------------------------------------------
   // Request decode
   // ----------------------------------------------------------------
   sfr_pkg::sfr_req_t req;
   sfr_pkg::sfr_dec_t dec;
   logic [7:0] power_control_ff;
   logic [7:0] ext_irq_priority_one_ff;
   logic stop_pend_ff;
   logic stop_ff;
   logic ext_meta_ff;
   logic ext_sync_ff;
   logic det_meta_ff;
   logic det_sync_ff;
   logic take_c;
   logic [2:0] id_c;
   logic legal;
   logic byte_ok;
   logic [7:0] nxt_power_control;
   logic [7:0] nxt_prio;
   logic [7:0] bit_mask;
   logic wr_pwr;
   logic wr_prio;
   logic [7:0] reg_rd;
   logic reset_cause;
   logic arb_resetn;

   // Group bus signals into one request word.
   always_comb
   begin
      req.rd = acc_rd;
      req.wr = acc_wr;
      req.bit_op = acc_bit_op;
      req.bit_sel = acc_bit_sel;
      req.addr = acc_addr;
      req.wdata = acc_wdata;
   end

   sfr_decode u_decode
   (
      .req(req),
      .dec(dec)
   );

   // Bit operations are only legal on bit-addressable columns.
   always_comb
   begin
      byte_ok = !acc_bit_op || dec.bit_ok;
      legal = dec.sfr_sel && byte_ok;
      bit_mask = 8'h01 << acc_bit_sel;
      wr_pwr = acc_wr && dec.pwr_hit && byte_ok && !stop_ff;
      wr_prio = acc_wr && dec.prio_hit && byte_ok && !stop_ff;
   end

   // ----------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------
   // External reset request comes from a pin and passes two stages first.
   always_ff @(posedge clk_sys)
   begin
      if (!resetn)
      begin
         ext_meta_ff <= 1'b0;
         ext_sync_ff <= 1'b0;
      end
      else
      begin
         ext_meta_ff <= ext_reset_req;
         ext_sync_ff <= ext_meta_ff;
      end
   end

   // Detector timeout comes from outside the clock domain and passes two stages first.
   always_ff @(posedge clk_sys)
   begin
      if (!resetn)
      begin
         det_meta_ff <= 1'b0;
         det_sync_ff <= 1'b0;
      end
      else
      begin
         det_meta_ff <= detector_timeout;
         det_sync_ff <= det_meta_ff;
      end
   end

   // Detector reset counts only when enabled; any cause also restarts the arbiter.
   always_comb
   begin
      reset_cause = ext_sync_ff || (detector_enable && det_sync_ff);
      arb_resetn = resetn && !reset_cause;
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   // Next power control value; bit writes touch a single bit.
   always_comb
   begin
      nxt_power_control = power_control_ff;
      if (wr_pwr)
      begin
         if (acc_bit_op)
            nxt_power_control = (power_control_ff & ~bit_mask) |
                                (acc_wdata[0] ? bit_mask : 8'h00);
         else
            nxt_power_control = acc_wdata;
      end
   end

   // Next priority value; reserved upper bits stay zero.
   always_comb
   begin
      nxt_prio = ext_irq_priority_one_ff;
      if (wr_prio)
         nxt_prio = acc_wdata & sfr_pkg::EXT_IRQ_PRIO_ONE_WMASK;
   end

   // Power control register; the stop bit clears itself when stop is entered.
   always_ff @(posedge clk_sys)
   begin
      if (!resetn || reset_cause)
         power_control_ff <= sfr_pkg::POWER_CONTROL_RESET;
      else if (stop_pend_ff && instr_done)
         power_control_ff <= power_control_ff & ~(8'h01 << sfr_pkg::STOP_BIT);
      else
         power_control_ff <= nxt_power_control;
   end

   // Extended priority register.
   always_ff @(posedge clk_sys)
   begin
      if (!resetn || reset_cause)
         ext_irq_priority_one_ff <= sfr_pkg::EXT_IRQ_PRIO_ONE_RESET;
      else
         ext_irq_priority_one_ff <= nxt_prio;
   end

   // ----------------------------------------------------------------
   // Stop mode
   // ----------------------------------------------------------------
   // A write of the stop bit arms entry; the arm drops when the instruction ends.
   always_ff @(posedge clk_sys)
   begin
      if (!resetn || reset_cause)
         stop_pend_ff <= 1'b0;
      else if (stop_pend_ff && instr_done)
         stop_pend_ff <= 1'b0;
      else if (wr_pwr && nxt_power_control[sfr_pkg::STOP_BIT])
         stop_pend_ff <= 1'b1;
   end

   // Stop begins as the arming instruction ends and is left only through a reset.
   always_ff @(posedge clk_sys)
   begin
      if (!resetn || reset_cause)
         stop_ff <= 1'b0;
      else if (stop_pend_ff && instr_done)
         stop_ff <= 1'b1;
   end

   // Run enables; the oscillator, core and peripherals are all stopped while stop is active.
   always_ff @(posedge clk_sys)
   begin
      if (!resetn)
      begin
         stop_mode <= 1'b0;
         osc_run <= 1'b1;
         core_run <= 1'b1;
         periph_run <= 1'b1;
      end
      else
      begin
         stop_mode <= stop_ff;
         osc_run <= !stop_ff;
         core_run <= !stop_ff;
         periph_run <= !stop_ff;
      end
   end

   // Reset signalling to the core; every restart fetches from the reset vector.
   always_ff @(posedge clk_sys)
   begin
      if (!resetn)
      begin
         core_reset_req <= 1'b0;
         fetch_addr <= sfr_pkg::RESET_VECTOR;
      end
      else
      begin
         core_reset_req <= reset_cause;
         fetch_addr <= sfr_pkg::RESET_VECTOR;
      end
   end

   // ----------------------------------------------------------------
   // Read path and routing
   // ----------------------------------------------------------------
   // Local registers answer locally; others go to peripherals.
   always_comb
   begin
      reg_rd = periph_rdata;
      if (dec.pwr_hit)
         reg_rd = power_control_ff;
      else if (dec.prio_hit)
         reg_rd = ext_irq_priority_one_ff;
      if (acc_bit_op)
         reg_rd = {7'h00, |(reg_rd & bit_mask)};
   end

   // Registered read data; refused and non-register reads return zero.
   always_ff @(posedge clk_sys)
   begin
      if (!resetn)
         rdata <= 8'h00;
      else
         rdata <= (acc_rd && legal) ? reg_rd : 8'h00;
   end

   // Registered routing strobes.
   always_ff @(posedge clk_sys)
   begin
      if (!resetn)
      begin
         ram_sel <= 1'b0;
         periph_sel <= 1'b0;
         bit_refused <= 1'b0;
      end
      else
      begin
         ram_sel <= (acc_rd || acc_wr) && !dec.sfr_sel;
         periph_sel <= (acc_rd || acc_wr) && legal && !dec.pwr_hit && !dec.prio_hit;
         bit_refused <= (acc_rd || acc_wr) && dec.sfr_sel && !byte_ok;
      end
   end

   // ----------------------------------------------------------------
   // Interrupt levels
   // ----------------------------------------------------------------
   irq_level_arbiter u_arb
   (
      .clk_sys(clk_sys),
      .resetn(arb_resetn),
      .irq_req(irq_req),
      .level(ext_irq_priority_one_ff[5:0]),
      .irq_ack(irq_ack && !stop_ff),
      .irq_ret(irq_ret),
      .irq_take(take_c),
      .irq_id(id_c)
   );

   // Registered per-source levels as programmed.
   always_ff @(posedge clk_sys)
   begin
      if (!resetn)
         irq_level <= 6'h00;
      else
         irq_level <= ext_irq_priority_one_ff[5:0];
   end

   // Registered arbiter result; nothing is offered while the core is stopped.
   always_ff @(posedge clk_sys)
   begin
      if (!resetn)
      begin
         irq_take <= 1'b0;
         irq_id <= 3'h0;
      end
      else
      begin
         irq_take <= take_c && !stop_ff;
         irq_id <= id_c;
      end
   end

endmodule : core_sfr_space_priority_stop

// ### test/core_sfr_sva.sv
// Checker for the register window, priority register and stop control.
`timescale 1ns/1ps
module core_sfr_sva
(
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic ext_reset_req,
   input wire logic detector_enable,
   input wire logic detector_timeout,
   input wire logic acc_rd,
   input wire logic acc_wr,
   input wire logic acc_bit_op,
   input wire logic [7:0] acc_addr,
   input wire logic [7:0] acc_wdata,
   input wire logic instr_done,
   input wire logic [7:0] rdata,
   input wire logic ram_sel,
   input wire logic bit_refused,
   input wire logic stop_mode,
   input wire logic osc_run,
   input wire logic core_run,
   input wire logic periph_run,
   input wire logic core_reset_req,
   input wire logic [7:0] fetch_addr,
   input wire logic [5:0] irq_level
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   logic [2:0] quiet_ff;
   logic [5:0] wcap_ff;
   wire acc = (acc_rd | acc_wr) & !stop_mode & !core_reset_req;
   // Counts cycles free of external reset request and detector timeout, saturating at seven.
   always_ff @(posedge clk_sys)
   begin
      if (!resetn || ext_reset_req || detector_timeout)
         quiet_ff <= 3'h0;
      else if (quiet_ff != 3'h7)
         quiet_ff <= quiet_ff + 3'h1;
   end
   // Keeps the last value written to the priority register.
   always_ff @(posedge clk_sys)
   begin
      if (acc_wr && acc_addr == 8'hf3)
         wcap_ff <= acc_wdata[5:0];
   end
   sequence s_stop_arm;
      acc && acc_wr && !acc_bit_op && acc_addr == 8'h87 && acc_wdata[1] && quiet_ff == 3'h7
      ##1 !acc_wr ##1 instr_done;
   endsequence
   sequence s_ext_hold;
      ext_reset_req [*3];
   endsequence
   sequence s_det_hold;
      (detector_enable && detector_timeout) [*3];
   endsequence
   chk_ram_route: assert property (acc && !acc_addr[7] |=> ram_sel && rdata == 8'h00)
      else $error("low address not routed to ram");
   chk_sfr_route: assert property (acc && acc_addr[7] |=> !ram_sel)
      else $error("register address routed to ram");
   chk_bit_refuse: assert property (acc && acc_bit_op && acc_addr[7] && acc_addr[2:0] != 3'h0
      |=> bit_refused)
      else $error("bit access not refused");
   chk_bit_accept: assert property (acc && acc_bit_op && acc_addr[7] && acc_addr[2:0] == 3'h0
      |=> !bit_refused)
      else $error("bit access wrongly refused");
   chk_level_write: assert property (acc && acc_wr && !acc_bit_op && acc_addr == 8'hf3
      |=> ##[0:1] irq_level == wcap_ff)
      else $error("priority levels not taken from write");
   chk_rsvd_zero: assert property (acc && acc_rd && !acc_bit_op && acc_addr == 8'hf3
      |=> rdata[7:6] == 2'b00)
      else $error("reserved priority bits not zero");
   chk_stop_entry: assert property (s_stop_arm |-> ##[1:3] stop_mode)
      else $error("stop not entered after instruction");
   chk_stop_halt: assert property (stop_mode |-> !osc_run && !core_run && !periph_run)
      else $error("clock or core running in stop");
   chk_stop_hold: assert property (stop_mode && quiet_ff == 3'h7 |=> stop_mode)
      else $error("stop left without reset");
   chk_reset_exit: assert property (stop_mode ##0 s_ext_hold |-> ##[0:4] !stop_mode)
      else $error("external reset did not end stop");
   chk_detector_exit: assert property (stop_mode ##0 s_det_hold |-> ##[0:4] core_reset_req)
      else $error("detector timeout did not reset");
   chk_fetch_zero: assert property (core_reset_req |-> fetch_addr == 8'h00)
      else $error("restart address not zero");
endmodule : core_sfr_sva
bind core_sfr_space_priority_stop core_sfr_sva core_sfr_sva_i (.*);

// ### test/core_sfr_space_priority_stop_tb.sv
// Self-checking bench for the register window, priority register and stop control.
`timescale 1ns/1ps
module core_sfr_space_priority_stop_tb;
   logic clk_sys = 1'b0;
   logic resetn = 1'b0;
   logic ext_reset_req = 1'b0, detector_enable = 1'b0, detector_timeout = 1'b0;
   logic acc_rd = 1'b0, acc_wr = 1'b0, acc_bit_op = 1'b0, instr_done = 1'b0;
   logic irq_ack = 1'b0, irq_ret = 1'b0;
   logic [2:0] acc_bit_sel = 3'h0;
   logic [7:0] acc_addr = 8'h00, acc_wdata = 8'h00, periph_rdata = 8'h00;
   logic [5:0] irq_req = 6'h00;
   logic [7:0] rdata, fetch_addr, a;
   logic ram_sel, periph_sel, bit_refused, stop_mode, osc_run, core_run, periph_run;
   logic core_reset_req, irq_take, b, r;
   logic [5:0] irq_level;
   logic [2:0] irq_id;
   int n_fail = 0, check_count = 0, cyc = 0, prio_m = 0, e;
   // Free-running system clock.
   always #20 clk_sys = ~clk_sys;
   core_sfr_space_priority_stop core_sfr_space_priority_stop_i (.*);
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("BAD t=%0t seen %h want %h", $time, seen, exp);
      end
   endtask : chk
   task automatic cyc_n(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask : cyc_n
   // One access; its registered answer is in view on return.
   task automatic acc(input logic rd, input logic bop, input logic [7:0] ad, input logic [7:0] d);
      cyc_n(1);
      acc_rd = rd;
      acc_wr = !rd;
      acc_bit_op = bop;
      acc_addr = ad;
      acc_wdata = d;
      cyc_n(1);
      acc_rd = 1'b0;
      acc_wr = 1'b0;
      acc_bit_op = 1'b0;
   endtask : acc
   task automatic stop_in();
      acc(0, 0, 8'h87, 8'h02);
      chk({7'h0, stop_mode}, 8'h00);
      cyc_n(1);
      instr_done = 1'b1;
      cyc_n(1);
      instr_done = 1'b0;
      cyc_n(3);
      chk({stop_mode, osc_run, core_run, periph_run}, 8'h08);
   endtask : stop_in
   task automatic conclude();
      $display("checks %0d fails %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : conclude
   // Cuts a hung run short.
   always @(posedge clk_sys)
   begin
      cyc++;
      if (cyc > 3000)
      begin
         n_fail++;
         conclude();
      end
   end
   initial
   begin
      e = $urandom(32'h0164);
      cyc_n(2);
      resetn = 1'b1;
      acc(1, 0, 8'h87, 8'h00);
      chk(rdata, 8'h00);
      acc(1, 0, 8'hf3, 8'h00);
      chk(rdata, 8'h00);
      for (int i = 0; i < 8; i++)
      begin
         a = (i < 6) ? 8'h01 << i : 8'($urandom);
         acc(0, 0, 8'hf3, a);
         prio_m = a & 8'h3f;
         acc(1, i[0], 8'hf3, 8'h00);
         chk(rdata, i[0] ? 8'h00 : 8'(prio_m));
         chk({2'h0, irq_level}, 8'(prio_m));
      end
      $display("priority register done");
      for (int i = 0; i < 12; i++)
      begin
         a = 8'($urandom);
         if (a[7])
            a[2:0] = {2'h0, !i[1]};
         if (a == 8'h91)
            a = 8'h99;
         b = a[7] & i[0];
         r = b && a[2:0] != 3'h0;
         periph_rdata = 8'($urandom);
         acc_bit_sel = 3'($urandom);
         acc(1, b, a, 8'h00);
         chk({5'h0, ram_sel, periph_sel, bit_refused}, {5'h0, !a[7], a[7] & !r, r});
         e = b ? periph_rdata[acc_bit_sel] : periph_rdata;
         chk(rdata, (a[7] && !r) ? 8'(e) : 8'h00);
      end
      $display("routing done");
      for (int i = 0; i < 5; i++)
      begin
         prio_m = (i == 4) ? 8'h04 : $urandom & 8'h3f;
         acc(0, 0, 8'hf3, 8'(prio_m));
         irq_req = (i == 4) ? 6'h01 : 6'($urandom) | 6'h20;
         cyc_n(2);
         e = -1;
         for (int j = 5; j >= 0; j--)
            if (irq_req[j] && prio_m[j])
               e = j;
         for (int j = 0; j < 6; j++)
            if (irq_req[j] && e < 0)
               e = j;
         chk({4'h0, irq_take, irq_id}, 8'h08 | 8'(e));
      end
      irq_ack = 1'b1;
      cyc_n(1);
      irq_ack = 1'b0;
      irq_req = 6'h05;
      cyc_n(2);
      chk({4'h0, irq_take, irq_id}, 8'h0a);
      irq_req = 6'h01;
      cyc_n(2);
      chk({4'h0, irq_take, irq_id}, 8'h00);
      irq_ret = 1'b1;
      cyc_n(1);
      irq_ret = 1'b0;
      cyc_n(2);
      chk({4'h0, irq_take, irq_id}, 8'h08);
      irq_req = 6'h00;
      $display("interrupt levels done");
      stop_in();
      acc(0, 0, 8'hf3, 8'h3f);
      detector_timeout = 1'b1;
      cyc_n(8);
      detector_timeout = 1'b0;
      chk({2'h0, irq_level}, 8'(prio_m));
      chk({7'h0, stop_mode}, 8'h01);
      ext_reset_req = 1'b1;
      cyc_n(4);
      ext_reset_req = 1'b0;
      cyc_n(5);
      chk({stop_mode, osc_run, core_run, periph_run}, 8'h07);
      chk(fetch_addr, 8'h00);
      acc(1, 0, 8'hf3, 8'h00);
      chk(rdata, 8'h00);
      detector_enable = 1'b1;
      stop_in();
      detector_timeout = 1'b1;
      cyc_n(4);
      chk({7'h0, core_reset_req}, 8'h01);
      detector_timeout = 1'b0;
      cyc_n(5);
      chk({7'h0, stop_mode}, 8'h00);
      $display("stop mode done");
      conclude();
   end
endmodule : core_sfr_space_priority_stop_tb
